/* core/seps_fifo.sv */
// write buffer between the serial side and the memory array
module seps_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("seps_fifo: depth must be a power of two >= 2");
   end

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } seps_fifo_regs_t;

   seps_fifo_regs_t         r;
   seps_fifo_regs_t         n;
   logic [WIDTH-1:0]        mem [DEPTH];
   logic                    do_push;
   logic                    do_pop;

   // full when pointers differ only in the wrap bit
   assign in_ready  = !((r.wr_ptr[AW] != r.rd_ptr[AW]) &&
                        (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]));
   assign out_valid = (r.wr_ptr != r.rd_ptr);
   assign out_data  = mem[r.rd_ptr[AW-1:0]];
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   // pointer update
   always_comb begin
      n = r;
      if (do_push) begin
         n.wr_ptr = r.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         n.rd_ptr = r.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[r.wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule

/* core/seps_pkg.sv */
// constants and types shared by the serial memory slave port
package seps_pkg;

   // clock and internal write cycle timing
   localparam int unsigned CLK_HZ             = 20_000_000;
   localparam int unsigned WRITE_CYCLE_MS     = 5;
   // longest time, so the division rounds down
   localparam int unsigned WRITE_CYCLE_CYCLES =
      WRITE_CYCLE_MS * (CLK_HZ / 1000);
   // three clocks from the stop on the pin to busy, plus the cycle busy holds at timer zero
   localparam int unsigned STOP_LATENCY       = 4;
   // fastest serial clock the master may run
   localparam int unsigned SCL_MAX_KHZ        = 400;

   // array and word geometry
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned MEM_DEPTH  = 256;
   localparam int unsigned SEL_W      = 3;
   localparam int unsigned CODE_W     = 4;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned FIFO_W     = 2 * BYTE_W;

   // device type code; the value is arbitrary
   localparam logic [3:0] DEVICE_CODE_DEFAULT = 4'h5;

   // bit counter value at the end of a byte
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // which byte of a frame is being received
   localparam logic [1:0] BI_DEV   = 2'h0;
   localparam logic [1:0] BI_MADDR = 2'h1;
   localparam logic [1:0] BI_DATA  = 2'h2;

   // protocol states, gray along idle-rx-ack-tx-mack
   typedef enum logic [2:0] {
      SEPS_IDLE = 3'h0,
      SEPS_RX   = 3'h1,
      SEPS_ACK  = 3'h3,
      SEPS_TX   = 3'h2,
      SEPS_MACK = 3'h6
   } seps_state_t;

endpackage

/* core/seps_slave.sv */
// two-wire slave port of a 256 x 8 nonvolatile memory

// Summary of operation
// - Data is sampled on serial clock rise and driven out on its fall.
// - The data line is only pulled low or released, never driven high.
// - Data changes only while the clock is low; changes with it high frame.
// - The port answers only when the received select bits match its pins.
// - Data bytes received while the lock pin is high never reach the memory array.
// - When locked, address bytes are acknowledged but data bytes are not.
// - While the lock pin is low, every location may be written.
// - Reads work the same whatever the lock pin level.
// - The internal write cycle ends at most 5 ms after the stop.
// - The address byte is type code, three select bits, then direction.
// - Each byte is followed by a ninth-clock acknowledge from the receiver.
// - A stop after written data starts the write cycle; inputs are ignored.
// - During the write cycle an address is not acknowledged, after it is.
module seps_slave #(
   parameter int unsigned TWC_CYCLES  = seps_pkg::WRITE_CYCLE_CYCLES,
   parameter logic [3:0]  DEVICE_CODE = seps_pkg::DEVICE_CODE_DEFAULT
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [2:0] hardwired_select_pins,
   input  wire logic       write_lock,
   output logic            write_busy
);

   // the buffer must drain and the stop latency fit inside the cycle
   if (TWC_CYCLES <
       seps_pkg::FIFO_DEPTH + seps_pkg::STOP_LATENCY) begin : g_chk
      $error("seps_slave: write cycle count too short for the buffer");
   end

   // state of the port apart from the array and the write buffer
   typedef struct packed {
      logic [1:0]           scl_sync;
      logic [1:0]           sda_sync;
      logic [2:0]           sel_s1;
      logic [2:0]           sel_s2;
      logic [1:0]           lock_sync;
      logic                 scl_prev;
      logic                 sda_prev;
      seps_pkg::seps_state_t state;
      logic [3:0]           cnt;
      logic [1:0]           idx;
      logic [7:0]           shift;
      logic [7:0]           addr;
      logic                 rd;
      logic                 sda_oe;
      logic                 wrote;
      logic                 busy;
      logic [31:0]          timer;
   } seps_regs_t;

   seps_regs_t   r;
   seps_regs_t   n;
   logic [7:0]   mem [seps_pkg::MEM_DEPTH];
   logic [7:0]   rd_byte;
   logic         scl;
   logic         sda;
   logic         rise;
   logic         fall;
   logic         start_cond;
   logic         stop_cond;
   logic         push_valid;
   logic         push_ready;
   logic [15:0]  push_data;
   logic         drain_valid;
   logic [15:0]  drain_data;
   logic         dev_match;

   // synchronised levels and their edges
   assign scl        = r.scl_sync[1];
   assign sda        = r.sda_sync[1];
   assign rise       = scl && !r.scl_prev;
   assign fall       = !scl && r.scl_prev;
   assign start_cond = scl && r.scl_prev && !sda && r.sda_prev;
   assign stop_cond  = scl && r.scl_prev && sda && !r.sda_prev;
   assign rd_byte    = mem[r.addr];
   assign push_data  = {r.addr, r.shift};

   // type code, select bits and not busy
   assign dev_match = (r.shift[7:4] == DEVICE_CODE) &&
                      (r.shift[3:1] == r.sel_s2) &&
                      !r.busy;

   // open drain: the line is only ever pulled low
   assign sda_out    = 1'b0;
   assign sda_oe     = r.sda_oe;
   assign write_busy = r.busy;

   // next state of the port
   always_comb begin
      n = r;
      push_valid = 1'b0;

      // two flip-flops on every pin input
      n.scl_sync  = {r.scl_sync[0], scl_in};
      n.sda_sync  = {r.sda_sync[0], sda_in};
      n.sel_s1    = hardwired_select_pins;
      n.sel_s2    = r.sel_s1;
      n.lock_sync = {r.lock_sync[0], write_lock};
      n.scl_prev  = r.scl_sync[1];
      n.sda_prev  = r.sda_sync[1];

      // internal write cycle timer, buffer drains meanwhile
      if (r.busy) begin
         if (r.timer != 32'h0) begin
            n.timer = r.timer - 32'h1;
         end else if (!drain_valid) begin
            n.busy = 1'b0;
         end
      end

      if (stop_cond) begin
         n.state  = seps_pkg::SEPS_IDLE;
         n.sda_oe = 1'b0;
         if (r.wrote && !r.busy) begin
            n.wrote = 1'b0;
            n.busy  = 1'b1;
            // stop is seen late, so that delay comes off the count
            n.timer = TWC_CYCLES - seps_pkg::STOP_LATENCY;
         end
      end else if (start_cond) begin
         n.state  = seps_pkg::SEPS_RX;
         n.idx    = seps_pkg::BI_DEV;
         n.cnt    = 4'h0;
         n.sda_oe = 1'b0;
      end else begin
         unique case (r.state)
            seps_pkg::SEPS_IDLE: begin
               n.sda_oe = 1'b0;
            end
            seps_pkg::SEPS_RX: begin
               if (rise && r.cnt != seps_pkg::BITS_PER_BYTE) begin
                  // sample msb first
                  n.shift = {r.shift[6:0], sda};
                  n.cnt   = r.cnt + 4'h1;
               end else if (fall && r.cnt == seps_pkg::BITS_PER_BYTE) begin
                  n.cnt   = 4'h0;
                  n.state = seps_pkg::SEPS_IDLE;
                  if (r.idx == seps_pkg::BI_DEV) begin
                     if (dev_match) begin
                        n.sda_oe = 1'b1;
                        n.rd     = r.shift[0];
                        n.idx    = seps_pkg::BI_MADDR;
                        n.state  = seps_pkg::SEPS_ACK;
                     end
                  end else if (r.idx == seps_pkg::BI_MADDR) begin
                     // acknowledged even when locked
                     n.addr   = r.shift;
                     n.sda_oe = 1'b1;
                     n.idx    = seps_pkg::BI_DATA;
                     n.state  = seps_pkg::SEPS_ACK;
                  end else if (!r.lock_sync[1] && push_ready) begin
                     // buffer byte, roll within the 16 byte page
                     push_valid   = 1'b1;
                     n.addr[3:0]  = r.addr[3:0] + 4'h1;
                     n.wrote      = 1'b1;
                     n.sda_oe     = 1'b1;
                     n.state      = seps_pkg::SEPS_ACK;
                  end
                  // locked data byte: line left released, no ack
               end
            end
            seps_pkg::SEPS_ACK: begin
               if (fall) begin
                  n.cnt    = 4'h0;
                  n.sda_oe = 1'b0;
                  n.state  = seps_pkg::SEPS_RX;
                  if (r.rd) begin
                     // first read bit goes out on this fall
                     n.sda_oe = !rd_byte[7];
                     n.shift  = {rd_byte[6:0], 1'b0};
                     n.cnt    = 4'h1;
                     n.addr   = r.addr + 8'h1;
                     n.state  = seps_pkg::SEPS_TX;
                  end
               end
            end
            seps_pkg::SEPS_TX: begin
               if (fall) begin
                  if (r.cnt == seps_pkg::BITS_PER_BYTE) begin
                     // release for the master's acknowledge
                     n.sda_oe = 1'b0;
                     n.state  = seps_pkg::SEPS_MACK;
                  end else begin
                     n.sda_oe = !r.shift[7];
                     n.shift  = {r.shift[6:0], 1'b0};
                     n.cnt    = r.cnt + 4'h1;
                  end
               end
            end
            seps_pkg::SEPS_MACK: begin
               if (rise) begin
                  if (!sda) begin
                     // master wants the next byte
                     n.shift = rd_byte;
                     n.addr  = r.addr + 8'h1;
                     n.cnt   = 4'h0;
                     n.state = seps_pkg::SEPS_TX;
                  end else begin
                     n.state = seps_pkg::SEPS_IDLE;
                  end
               end
            end
            default: begin
               n.state  = seps_pkg::SEPS_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // written bytes wait here until the stop
   seps_fifo #(
      .WIDTH (seps_pkg::FIFO_W),
      .DEPTH (seps_pkg::FIFO_DEPTH)
   ) u_wbuf (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (drain_valid),
      .out_ready (r.busy),
      .out_data  (drain_data)
   );

   // commit buffered bytes only during the write cycle
   always_ff @(posedge clk) begin
      if (drain_valid && r.busy) begin
         mem[drain_data[15:8]] <= drain_data[7:0];
      end
   end

endmodule

/* test/seps_master.sv */
// two-wire bus master model, open-drain data
module seps_master (
   input  wire logic clk,
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // quarter bit of 650 ns keeps the clock under 400 kHz
   localparam int Q = 650;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // data moves mid low phase, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      #Q sda_low = !b;
      #Q scl = 1'b1;
      #(2*Q) r = sda;
      scl = 1'b0;
   endtask
   // start or repeated start, ends with clock low
   task automatic start();
      @(negedge clk);
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda_low = 1'b1;
      #(2*Q) scl = 1'b0;
   endtask
   // stop from clock low, bus left idle high
   task automatic stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_low = 1'b0;
      #(2*Q);
   endtask
   // byte msb first, ninth clock carries bit mb
   task automatic xfer(input logic [7:0] d, input logic mb,
                       output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(mb, a);
   endtask
endmodule

/* test/seps_slave_asserts.sv */
// port checks for the serial memory slave port
module seps_slave_asserts #(
   parameter int unsigned TWC_CYCLES = 100
) (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [2:0] hardwired_select_pins,
   input wire logic       write_lock,
   input wire logic       write_busy
);
   int unsigned busy_cnt_ff;
   // length of the current write cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= write_busy ? busy_cnt_ff + 1 : 0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_od; sda_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("data driven high");
   property p_oe_low; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe_low: assert property (p_oe_low) else $error("oe moved, scl high");
   property p_oe_fall; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("oe early");
   property p_bmin; $rose(write_busy) |-> write_busy [*8]; endproperty
   a_bmin: assert property (p_bmin) else $error("cycle too short");
   // stop takes three clocks to raise busy, so busy gets the rest
   property p_bmax; busy_cnt_ff <= TWC_CYCLES - 3; endproperty
   a_bmax: assert property (p_bmax) else $error("cycle too long");
   property p_bstop;
      $rose(write_busy) |-> scl_in && sda_in && !$past(sda_in, 6);
   endproperty
   a_bstop: assert property (p_bstop) else $error("cycle without stop");
   property p_bnack; write_busy |-> !sda_oe; endproperty
   a_bnack: assert property (p_bnack) else $error("ack while busy");
   property p_lock; $rose(write_busy) |-> !$past(write_lock, 8); endproperty
   a_lock: assert property (p_lock) else $error("locked write ran");
   c_wr: cover property ($rose(write_busy));
   c_done: cover property ($fell(write_busy));
   c_lack: cover property (write_lock && sda_oe);
endmodule
bind seps_slave seps_slave_asserts #(.TWC_CYCLES(TWC_CYCLES)) chk_i (
   .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .write_lock(write_lock),
   .hardwired_select_pins(hardwired_select_pins),
   .write_busy(write_busy));

/* test/seps_slave_tb_top.sv */
// self-checking bench for the serial memory slave port
module seps_slave_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned INTERNAL_WRITE_CYCLE_TIME = 2000;
   localparam logic [2:0] SEL = 3'h5;
   logic clk, resetn, scl, sda, m_low, sda_out, sda_oe, lock, busy;
   logic [2:0] sel;
   int bad_count;
   int checks;
   // open-drain wire with pull-up
   assign sda = !m_low && (!sda_oe || sda_out);
   seps_master m (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
   seps_slave #(.TWC_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) uut (.clk(clk), .resetn(resetn),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .hardwired_select_pins(sel), .write_lock(lock), .write_busy(busy));
   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
      return {seps_pkg::DEVICE_CODE_DEFAULT, s, rw};
   endfunction
   // one byte from the master, slave answer compared
   task automatic send(input logic [7:0] b, input logic e);
      logic [7:0] r;
      logic a;
      m.xfer(b, 1'b1, r, a);
      chk("ack", {7'h0, e}, {7'h0, a});
   endtask
   // byte write, busy flag, polling during and after the cycle
   task automatic t_write(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      send(a, 1'b0);
      send(d, 1'b0);
      m.stop();
      chk("busy", 8'h1, {7'h0, busy});
      m.start();
      send(dev(SEL, 1'b0), 1'b1);
      m.stop();
      while (busy !== 1'b0 && n < INTERNAL_WRITE_CYCLE_TIME + 40) begin
         @(negedge clk);
         n++;
      end
      chk("internal_write_cycle_time", 8'h1, {7'h0, n < INTERNAL_WRITE_CYCLE_TIME});
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      m.stop();
   endtask
   // random read: address set, repeated start, one byte
   task automatic t_read(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic k;
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      send(a, 1'b0);
      m.start();
      send(dev(SEL, 1'b1), 1'b0);
      m.xfer(8'hFF, 1'b1, r, k);
      chk("read", e, r);
      m.stop();
   endtask
   // every select code and a wrong type code
   task automatic t_sel();
      for (int s = 0; s < 8; s++) begin
         m.start();
         send(dev(3'(s), 1'b0), s != SEL);
         m.stop();
      end
      m.start();
      send(dev(SEL, 1'b0) ^ 8'h80, 1'b1);
      m.stop();
   endtask
   // locked write: address acks, data nack, array unchanged
   task automatic t_lock(input logic [7:0] a, d, e);
      lock = 1'b1;
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      send(a, 1'b0);
      send(d, 1'b1);
      m.stop();
      chk("busy", 8'h0, {7'h0, busy});
      t_read(a, e);
      lock = 1'b0;
   endtask
   // two-byte page write whose second byte rolls over in the page
   task automatic t_page(input logic [7:0] a, d0, d1);
      int n;
      n = 0;
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      send(a, 1'b0);
      send(d0, 1'b0);
      send(d1, 1'b0);
      m.stop();
      while (busy !== 1'b0 && n < INTERNAL_WRITE_CYCLE_TIME + 40) begin
         @(negedge clk);
         n++;
      end
      chk("internal_write_cycle_time", 8'h1, {7'h0, n < INTERNAL_WRITE_CYCLE_TIME});
      t_read(a, d0);
      t_read({a[7:4], 4'h0}, d1);
   endtask
   // sequential read, master acks the first byte
   task automatic t_seq(input logic [7:0] a, e0, e1);
      logic [7:0] r;
      logic k;
      m.start();
      send(dev(SEL, 1'b0), 1'b0);
      send(a, 1'b0);
      m.start();
      send(dev(SEL, 1'b1), 1'b0);
      m.xfer(8'hFF, 1'b0, r, k);
      chk("seq0", e0, r);
      m.xfer(8'hFF, 1'b1, r, k);
      chk("seq1", e1, r);
      m.stop();
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end
   // watchdog against a hung handshake
   initial begin
      #3ms;
      bad_count++;
      test_done();
   end
   // main sequence
   initial begin
      bad_count = 0;
      checks = 0;
      resetn = 1'b0;
      sel = SEL;
      lock = 1'b0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      t_write(8'h00, 8'hA5);
      t_read(8'h00, 8'hA5);
      t_write(8'hFF, 8'h3C);
      t_read(8'hFF, 8'h3C);
      t_sel();
      t_lock(8'hFF, 8'h11, 8'h3C);
      t_page(8'h2F, 8'h12, 8'h34);
      t_seq(8'hFF, 8'h3C, 8'hA5);
      test_done();
   end
endmodule
